// ---- counter_pkg.sv ----
// constants for the sixteen bit timer/counter: register offsets, field
// positions, reset values.
// assumes a plain strobe register port with 8 bit data in the low bits.
package counter_pkg;
   // ==========================================================
   // register offsets
   localparam logic [7:0] OFF_COUNT_LOW   = 8'h0E;
   localparam logic [7:0] OFF_COUNT_HIGH  = 8'h0F;
   localparam logic [7:0] OFF_CONTROL     = 8'h10;
   localparam logic [7:0] OFF_FLAG        = 8'h0C;
   localparam logic [7:0] OFF_ENABLE      = 8'h8C;
   localparam logic [7:0] OFF_PINS        = 8'h20;
   localparam logic [7:0] OFF_DIRECTION   = 8'h21;
   // ==========================================================
   // counter_control fields
   localparam int BIT_RUN      = 0;
   localparam int BIT_SOURCE   = 1;
   localparam int BIT_BYPASS   = 2;
   localparam int BIT_OSC_EN   = 3;
   localparam int BIT_PRE_LO   = 4;
   localparam int BIT_PRE_HI   = 5;
   localparam logic [7:0] CONTROL_MASK  = 8'h3F;
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   // flag and enable registers, pin direction reset
   localparam int BIT_OVERFLOW = 0;
   localparam logic [7:0] PIN_DIR_RESET = 8'h03;
   // oscillator pin positions in the pin/direction registers
   localparam int BIT_PIN_OSC_OUT = 0;
   localparam int BIT_PIN_OSC_IN  = 1;
   // prescaler width (divide up to 1:8)
   localparam int PRESCALE_BITS = 3;
endpackage

// ---- edge_sync.sv ----
// two-flop synchroniser with rising and falling edge pulses.
// assumes input comes from outside the clock domain.
`timescale 1ns/100ps
`default_nettype none
module edge_sync (
   input  wire logic clock,
   input  wire logic rst_n,
   input  wire logic async_in,
   output logic      level,
   output logic      rise,
   output logic      fall
);
   // ==========================================================
   // synchroniser state
   logic meta_q, meta_d;   // first stage, read only by second
   logic sync_q, sync_d;   // second stage
   logic last_q, last_d;   // previous settled value for edges

   // next values
   always_comb begin
      meta_d = async_in;
      sync_d = meta_q;
      last_d = sync_q;
   end

   // registers
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         last_q <= 1'b0;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
         last_q <= last_d;
      end
   end

   assign level = sync_q;
   assign rise  = sync_q & ~last_q;
   assign fall  = ~sync_q & last_q;
endmodule
`default_nettype wire

// ---- timer_counter.sv ----
// sixteen bit timer/counter with prescaler, overflow flag and
// capture/compare special event clear.
// assumes one 25 MHz core clock (instruction clock); external count
// pins are sampled through two flops, so the asynchronous mode is modelled
// as the synchronous one but kept counting during sleep.
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// RULE1: sixteen bit counter, two byte registers, wraps
// RULE2: overflow latches flag; enable gates interrupt
// RULE3: source bit picks instruction clock or pin
// RULE4: run bit enables counting, clear holds
// RULE5: prescale field divides by 1,2,4,8
// RULE6: oscillator enable forces pins input, read zero
// RULE7: bypass bit chooses sync; ignored in timer mode
// RULE8: falling edge needed before first count
// RULE9: osc enable picks osc_in else ext clock
// RULE10: synchronise prescaler output; prescaler ripples
// RULE11: sync mode sleeps frozen, prescaler keeps counting
// RULE12: async mode counts in sleep, overflow wakes
// RULE13: async count not a capture time base
// RULE14: async byte reads return stable values
// RULE15: software reads high, low, high again
// RULE16: software stops counter before async writes
// RULE17: special event trigger clears the count; the code skips the clear in asynchronous counter mode
// RULE18: oscillator enable bit runs or stops oscillator
// RULE19: software waits oscillator start-up before use
// RULE20: control bits seven and six read zero
// RULE21: write beats special event clear
// RULE22: count bytes survive device reset
// RULE23: control cleared by power-on reset
// RULE24: count byte write clears prescaler
// RULE25: flag set on wrap, held until cleared
module timer_counter (
   input  wire logic       clock,
   input  wire logic       rst_n,
   input  wire logic [7:0] address,
   input  wire logic [7:0] write_data,
   input  wire logic       write_strobe,
   input  wire logic       read_strobe,
   output logic      [7:0] read_data,
   input  wire logic       sleep_mode,
   input  wire logic       special_event,
   input  wire logic       osc_in_pin,
   input  wire logic       ext_clock_pin,
   output logic            osc_run,
   output logic            osc_in_oe_n,
   output logic            ext_clock_oe_n,
   output logic            overflow_irq,
   output logic            wake_request,
   output logic            timebase_valid,
   output logic     [15:0] timebase_count
);
   // ==========================================================
   // registers
   logic [7:0]  control_q, control_d;       // counter_control
   logic [7:0]  low_q, low_d;               // count_low_byte
   logic [7:0]  high_q, high_d;             // count_high_byte
   logic        flag_q, flag_d;             // overflow_flag
   logic        irq_en_q, irq_en_d;         // overflow_irq_enable
   logic [1:0]  dir_q, dir_d;               // port_direction, osc pins
   logic [2:0]  pre_q, pre_d;               // prescaler count
   logic        armed_q, armed_d;           // falling edge seen
   logic [7:0]  rdata_q, rdata_d;           // read data
   logic        irq_q, irq_d;
   logic        wake_q, wake_d;
   logic        tbv_q, tbv_d;
   logic [15:0] tbc_q, tbc_d;
   logic        oe_in_q, oe_in_d;
   logic        oe_ext_q, oe_ext_d;
   logic        osc_q, osc_d;
   logic        run_q;                      // previous run bit

   // ==========================================================
   // field decode
   logic       run, ext_src, bypass, osc_en;
   logic [1:0] pre_sel;
   assign run     = control_q[counter_pkg::BIT_RUN];
   assign ext_src = control_q[counter_pkg::BIT_SOURCE];
   assign bypass  = control_q[counter_pkg::BIT_BYPASS];
   assign osc_en  = control_q[counter_pkg::BIT_OSC_EN];
   assign pre_sel = control_q[counter_pkg::BIT_PRE_HI:counter_pkg::BIT_PRE_LO];

   // ==========================================================
   // pin synchronisers
   logic osc_lvl, osc_rise, osc_fall;
   logic ext_lvl, ext_rise, ext_fall;
   edge_sync u_osc_sync (
      .clock    (clock),
      .rst_n    (rst_n),
      .async_in (osc_in_pin),
      .level    (osc_lvl),
      .rise     (osc_rise),
      .fall     (osc_fall)
   );
   edge_sync u_ext_sync (
      .clock    (clock),
      .rst_n    (rst_n),
      .async_in (ext_clock_pin),
      .level    (ext_lvl),
      .rise     (ext_rise),
      .fall     (ext_fall)
   );

   // ==========================================================
   // source selection and count enables
   logic src_rise, src_fall, src_lvl, tick, pre_out, count_en;
   logic wr_low, wr_high, wr_ctrl, wr_count;
   logic [15:0] count, count_next;
   always_comb begin
      // oscillator pin when the oscillator runs, else clock pin; see RULE9
      src_rise = osc_en ? osc_rise : ext_rise;
      src_fall = osc_en ? osc_fall : ext_fall;
      src_lvl  = osc_en ? osc_lvl  : ext_lvl;
      // instruction clock ticks every cycle; see RULE3
      if (!ext_src) begin
         tick = 1'b1;
      end else begin
         tick = src_rise & armed_q;   // see RULE8
      end
      // prescaler output pulse by selected ratio; see RULE5
      case (pre_sel)
         2'b00:   pre_out = tick;
         2'b01:   pre_out = tick & pre_q[0];
         2'b10:   pre_out = tick & (&pre_q[1:0]);
         2'b11:   pre_out = tick & (&pre_q[2:0]);
         default: pre_out = 1'b0;
      endcase
      // sleep stops timer and synchronised counter only; see RULE11 RULE12
      count_en = run & pre_out & ~(sleep_mode & ~(ext_src & bypass));   // see RULE4 RULE7
   end

   assign wr_low   = write_strobe && address == counter_pkg::OFF_COUNT_LOW;
   assign wr_high  = write_strobe && address == counter_pkg::OFF_COUNT_HIGH;
   assign wr_ctrl  = write_strobe && address == counter_pkg::OFF_CONTROL;
   assign wr_count = wr_low | wr_high;
   assign count      = {high_q, low_q};
   assign count_next = count + 16'h0001;

   // ==========================================================
   // counter, prescaler and arming next values
   always_comb begin
      pre_d   = pre_q;
      armed_d = armed_q;
      low_d   = low_q;
      high_d  = high_q;
      // prescaler advances on source ticks even in sleep; see RULE10 RULE11
      if (run && tick) begin
         pre_d = pre_q + 3'b001;
      end
      // arm on falling edge after enable in counter mode; see RULE8
      if (!run || !ext_src) begin
         armed_d = 1'b0;
      end else if (src_fall || (!src_lvl && run_q && armed_q)) begin
         armed_d = 1'b1;
      end
      if (wr_count) begin
         pre_d = 3'b000;   // see RULE24
      end
      if (wr_low || wr_high) begin
         // write wins over increment and special clear; see RULE21 RULE16
         if (wr_low) begin
            low_d = write_data;
         end
         if (wr_high) begin
            high_d = write_data;
         end
      end else if (special_event && !(ext_src && bypass)) begin
         // clear works in timer and synchronised modes; see RULE17
         low_d  = 8'h00;
         high_d = 8'h00;
      end else if (count_en) begin
         {high_d, low_d} = count_next;   // wraps ffff to 0000; see RULE1
      end
   end

   // ==========================================================
   // register file next values
   logic wrap;
   assign wrap = count_en && !wr_count && (count == 16'hFFFF)
                 && !(special_event && !(ext_src && bypass));
   always_comb begin
      control_d = control_q;
      flag_d    = flag_q;
      irq_en_d  = irq_en_q;
      dir_d     = dir_q;
      rdata_d   = 8'h00;
      if (wr_ctrl) begin
         control_d = write_data & counter_pkg::CONTROL_MASK;   // see RULE20
      end
      if (write_strobe && address == counter_pkg::OFF_FLAG) begin
         flag_d = write_data[counter_pkg::BIT_OVERFLOW];
      end
      if (write_strobe && address == counter_pkg::OFF_ENABLE) begin
         irq_en_d = write_data[counter_pkg::BIT_OVERFLOW];
      end
      if (write_strobe && address == counter_pkg::OFF_DIRECTION) begin
         dir_d = write_data[1:0];
      end
      // set beats a software clear; see RULE2 RULE25
      if (wrap) begin
         flag_d = 1'b1;
      end
      // reads of the bytes come from core-clock registers; see RULE14
      if (read_strobe) begin
         case (address)
            counter_pkg::OFF_COUNT_LOW:  rdata_d = low_q;
            counter_pkg::OFF_COUNT_HIGH: rdata_d = high_q;
            counter_pkg::OFF_CONTROL:    rdata_d = control_q;   // see RULE20
            counter_pkg::OFF_FLAG:       rdata_d = {7'h00, flag_q};
            counter_pkg::OFF_ENABLE:     rdata_d = {7'h00, irq_en_q};
            counter_pkg::OFF_DIRECTION:  rdata_d = {6'h00, dir_q};
            // oscillator pins read zero while it runs; see RULE6
            counter_pkg::OFF_PINS: begin
               rdata_d = osc_en ? 8'h00 : {6'h00, osc_lvl, ext_lvl};
            end
            default:                     rdata_d = 8'h00;
         endcase
      end
   end

   // ==========================================================
   // output next values
   always_comb begin
      irq_d    = flag_d & irq_en_d;                           // see RULE2
      wake_d   = flag_d & irq_en_d & ext_src & bypass & run;  // see RULE12
      tbv_d    = ~(control_d[counter_pkg::BIT_SOURCE] & control_d[counter_pkg::BIT_BYPASS]); // see RULE13
      tbc_d    = {high_d, low_d};
      // pins forced input while oscillator on; see RULE6
      oe_in_d  = control_d[counter_pkg::BIT_OSC_EN] | dir_d[counter_pkg::BIT_PIN_OSC_IN];
      oe_ext_d = control_d[counter_pkg::BIT_OSC_EN] | dir_d[counter_pkg::BIT_PIN_OSC_OUT];
      osc_d    = control_d[counter_pkg::BIT_OSC_EN];          // see RULE18
   end

   // ==========================================================
   // count bytes: no reset, only special event clears; see RULE22
   always_ff @(posedge clock) begin
      low_q  <= low_d;
      high_q <= high_d;
   end

   // control state under power-on reset; see RULE23
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         control_q <= counter_pkg::CONTROL_RESET;
         flag_q    <= 1'b0;
         irq_en_q  <= 1'b0;
         dir_q     <= counter_pkg::PIN_DIR_RESET[1:0];
         pre_q     <= 3'b000;
         armed_q   <= 1'b0;
         run_q     <= 1'b0;
         rdata_q   <= 8'h00;
         irq_q     <= 1'b0;
         wake_q    <= 1'b0;
         tbv_q     <= 1'b1;
         tbc_q     <= 16'h0000;
         oe_in_q   <= 1'b1;
         oe_ext_q  <= 1'b1;
         osc_q     <= 1'b0;
      end else begin
         control_q <= control_d;
         flag_q    <= flag_d;
         irq_en_q  <= irq_en_d;
         dir_q     <= dir_d;
         pre_q     <= pre_d;
         armed_q   <= armed_d;
         run_q     <= run;
         rdata_q   <= rdata_d;
         irq_q     <= irq_d;
         wake_q    <= wake_d;
         tbv_q     <= tbv_d;
         tbc_q     <= tbc_d;
         oe_in_q   <= oe_in_d;
         oe_ext_q  <= oe_ext_d;
         osc_q     <= osc_d;
      end
   end

   assign read_data      = rdata_q;
   assign overflow_irq   = irq_q;
   assign wake_request   = wake_q;
   assign timebase_valid = tbv_q;
   assign timebase_count = tbc_q;
   assign osc_in_oe_n    = oe_in_q;
   assign ext_clock_oe_n = oe_ext_q;
   assign osc_run        = osc_q;

   // ==========================================================
   // checks
   property p_wrap_flag;
      @(posedge clock) disable iff (!rst_n)
      wrap |=> flag_q && count == 16'h0000;
   endproperty
   a_wrap_flag: assert property (p_wrap_flag) else $error("wrap missed flag"); // see RULE25
   property p_stop_hold;
      @(posedge clock) disable iff (!rst_n)
      (!run && !wr_count && !special_event) |=> $stable(count);
   endproperty
   a_stop_hold: assert property (p_stop_hold) else $error("stopped count moved"); // see RULE4
   property p_timer_inc;
      @(posedge clock) disable iff (!rst_n)
      (run && !ext_src && pre_sel == 2'b00 && !sleep_mode && !wr_count && !special_event)
         |=> count == $past(count) + 16'h0001;
   endproperty
   a_timer_inc: assert property (p_timer_inc) else $error("timer did not step"); // see RULE3
   property p_write_wins;
      @(posedge clock) disable iff (!rst_n)
      (wr_low && special_event) |=> low_q == $past(write_data);
   endproperty
   a_write_wins: assert property (p_write_wins) else $error("clear beat write"); // see RULE21
   property p_pre_clear;
      @(posedge clock) disable iff (!rst_n)
      wr_count |=> pre_q == 3'b000;
   endproperty
   a_pre_clear: assert property (p_pre_clear) else $error("prescaler kept"); // see RULE24
   property p_ctrl_zero;
      @(posedge clock) disable iff (!rst_n)
      read_strobe && address == counter_pkg::OFF_CONTROL |=> read_data[7:6] == 2'b00;
   endproperty
   a_ctrl_zero: assert property (p_ctrl_zero) else $error("unused bits set"); // see RULE20
   property p_unarmed;
      @(posedge clock) disable iff (!rst_n)
      (ext_src && !armed_q && !wr_count && !special_event) |=> $stable(count);
   endproperty
   a_unarmed: assert property (p_unarmed) else $error("count before falling edge"); // see RULE8
   property p_pins_read_zero;
      @(posedge clock) disable iff (!rst_n)
      read_strobe && address == counter_pkg::OFF_PINS && osc_en |=> read_data == 8'h00;
   endproperty
   a_pins_read_zero: assert property (p_pins_read_zero) else $error("osc pins not zero"); // see RULE6
   property p_sync_sleep;
      @(posedge clock) disable iff (!rst_n)
      (sleep_mode && ext_src && !bypass && !wr_count && !special_event) |=> $stable(count);
   endproperty
   a_sync_sleep: assert property (p_sync_sleep) else $error("counted in sleep"); // see RULE11
   // arming: a falling edge while enabled in counter mode, then armed
   sequence s_fall_seen;
      run && ext_src && src_fall;
   endsequence
   sequence s_now_armed;
      armed_q;
   endsequence
   property p_arm_on_fall;
      @(posedge clock) disable iff (!rst_n)
      s_fall_seen |=> s_now_armed;
   endproperty
   a_arm_on_fall: assert property (p_arm_on_fall) else $error("fall did not arm"); // see RULE8
endmodule
`default_nettype wire

// ---- ext_clock_source.sv ----
// external count source: a square wave on one of the two count pins.
// assumes the bench opens and closes each burst; pins stand still between.
`timescale 1ns/100ps
`default_nettype none
module ext_clock_source #(
   parameter int HALF = 4  // core cycles per half period
) (
   input  wire logic clock,
   input  wire logic enable,
   input  wire logic use_osc,
   output logic      osc_in_pin,
   output logic      ext_clock_pin
);
   // ==========================================
   // toggle timer
   int tick_q;  // cycles since the last toggle
   // pins start low; a stopped source keeps its level, like a gated clock
   initial begin
      osc_in_pin = 1'b0;
      ext_clock_pin = 1'b0;
      tick_q = 0;
   end
   // toggle only the selected pin, so the other one never moves
   always @(posedge clock) begin
      if (!enable) begin
         tick_q <= 0;
      end else if (tick_q == HALF - 1) begin
         tick_q <= 0;
         if (use_osc) begin
            osc_in_pin <= ~osc_in_pin;
         end else begin
            ext_clock_pin <= ~ext_clock_pin;
         end
      end else begin
         tick_q <= tick_q + 1;
      end
   end
endmodule
`default_nettype wire

// ---- tb_timer_counter.sv ----
// self-checking bench for timer_counter with an external count source.
// assumes register map and field positions of counter_pkg.
`timescale 1ns/100ps
`default_nettype none
module tb_timer_counter;
   // ==========================================
   // signals
   logic        clock;
   logic        rst_n;
   logic [7:0]  address;
   logic [7:0]  write_data;
   logic        write_strobe;
   logic        read_strobe;
   logic [7:0]  read_data;
   logic        sleep_mode;
   logic        special_event;
   logic        osc_in_pin;
   logic        ext_clock_pin;
   logic        osc_run;
   logic        osc_in_oe_n;
   logic        ext_clock_oe_n;
   logic        overflow_irq;
   logic        wake_request;
   logic        timebase_valid;
   logic [15:0] timebase_count;
   logic        src_enable;   // burst gate for the source
   logic        src_use_osc;  // burst on oscillator pin, else clock pin
   logic [7:0]  got;          // last byte read
   logic [15:0] cnt;          // last count read
   int          err_total;
   int          num_checks;
   localparam int HALF = 4;
   localparam logic [7:0] CTL = counter_pkg::OFF_CONTROL;
   // ==========================================
   // instances
   timer_counter i_timer_counter (.clock, .rst_n, .address, .write_data, .write_strobe, .read_strobe,
      .read_data, .sleep_mode, .special_event, .osc_in_pin, .ext_clock_pin, .osc_run, .osc_in_oe_n,
      .ext_clock_oe_n, .overflow_irq, .wake_request, .timebase_valid, .timebase_count);
   ext_clock_source #(.HALF(HALF)) i_ext_clock_source (.clock, .enable(src_enable),
      .use_osc(src_use_osc), .osc_in_pin, .ext_clock_pin);
   // ==========================================
   // bus and helper tasks; each starts just after a rising edge
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic idle(input int n);
      write_strobe <= 1'b0;
      read_strobe <= 1'b0;
      repeat (n) @(posedge clock);
   endtask
   // strobe is left high so writes may follow with no gap
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      address <= a;
      write_data <= d;
      write_strobe <= 1'b1;
      read_strobe <= 1'b0;
      @(posedge clock);
   endtask
   // data stands only in the cycle after the strobe
   task automatic rd(input logic [7:0] a);
      address <= a;
      write_strobe <= 1'b0;
      read_strobe <= 1'b1;
      @(posedge clock);
      read_strobe <= 1'b0;
      #1 got = read_data;
      @(posedge clock);
   endtask
   // high, low, high; a changed high byte means a rollover, so low again
   task automatic rd16();
      logic [7:0] hi;
      rd(counter_pkg::OFF_COUNT_HIGH);
      hi = got;
      rd(counter_pkg::OFF_COUNT_LOW);
      cnt[7:0] = got;
      rd(counter_pkg::OFF_COUNT_HIGH);
      if (got !== hi) begin
         rd(counter_pkg::OFF_COUNT_LOW);
         cnt[7:0] = got;
         rd(counter_pkg::OFF_COUNT_HIGH);
      end
      cnt[15:8] = got;
   endtask
   // only called with the counter stopped
   task automatic load(input logic [15:0] v);
      wr(counter_pkg::OFF_COUNT_HIGH, v[15:8]);
      wr(counter_pkg::OFF_COUNT_LOW, v[7:0]);
      idle(1);
   endtask
   // run for exactly k core cycles, then stop
   task automatic run(input logic [7:0] ctl, input int k);
      wr(CTL, ctl);
      idle(k - 1);
      wr(CTL, 8'h00);
      idle(1);
   endtask
   // t toggles on one pin, then time for the two-flop sampling
   task automatic frame(input logic osc, input int t);
      // a strobe left high by wr must not repeat through the burst
      write_strobe <= 1'b0;
      read_strobe <= 1'b0;
      src_use_osc <= osc;
      src_enable <= 1'b1;
      repeat (t * HALF) @(posedge clock);
      src_enable <= 1'b0;
      idle(6);
   endtask
   // ==========================================
   // scenarios
   task automatic t_regs();
      rd16();
      check(cnt, 16'hA5C3);
      rd(CTL);
      check(got, 8'h00);
      rd(counter_pkg::OFF_DIRECTION);
      check(got, 8'h03);
      wr(8'h40, 8'hA5);
      rd(8'h40);
      check(got, 8'h00);
      wr(CTL, 8'hC8);
      rd(CTL);
      check(got, 8'h08);
      check(osc_run, 1'b1);
      frame(1'b1, 1);
      frame(1'b0, 1);
      wr(counter_pkg::OFF_DIRECTION, 8'h00);
      rd(counter_pkg::OFF_PINS);
      check(got, 8'h00);
      check({osc_in_oe_n, ext_clock_oe_n}, 2'b11);
      wr(CTL, 8'h00);
      rd(counter_pkg::OFF_PINS);
      check(got, 8'h03);
      check({osc_run, osc_in_oe_n, ext_clock_oe_n}, 3'b000);
      wr(counter_pkg::OFF_DIRECTION, 8'h03);
      frame(1'b1, 1);
      frame(1'b0, 1);
   endtask
   task automatic t_prescale();
      for (int ps = 0; ps < 4; ps++) begin
         load(16'h0000);
         run({2'b00, ps[1:0], 4'b0001}, 16);
         rd16();
         check(cnt, 16'(16 >> ps));
      end
      idle(5);
      rd16();
      check(cnt, 16'h0002);
      load(16'h0000);
      run(8'h05, 16);
      rd16();
      check(cnt, 16'h0010);
   endtask
   task automatic t_wrap();
      load(16'hFFFE);
      run(8'h01, 2);
      rd16();
      check(cnt, 16'h0000);
      rd(counter_pkg::OFF_FLAG);
      check(got, 8'h01);
      check(overflow_irq, 1'b0);
      wr(counter_pkg::OFF_ENABLE, 8'h01);
      idle(2);
      check(overflow_irq, 1'b1);
      wr(counter_pkg::OFF_FLAG, 8'h00);
      rd(counter_pkg::OFF_FLAG);
      check({got, overflow_irq}, 9'h000);
   endtask
   task automatic t_special();
      load(16'h1234);
      check(timebase_count, 16'h1234);
      special_event <= 1'b1;
      idle(1);
      special_event <= 1'b0;
      rd16();
      check(cnt, 16'h0000);
      special_event <= 1'b1;
      wr(counter_pkg::OFF_COUNT_LOW, 8'h55);
      special_event <= 1'b0;
      rd16();
      check(cnt, 16'h0055);
      wr(CTL, 8'h07);
      idle(2);
      check(timebase_valid, 1'b0);
      wr(CTL, 8'h05);
      idle(2);
      check(timebase_valid, 1'b1);
      wr(CTL, 8'h00);
   endtask
   // first rise of each burst comes before any fall, so it is not counted
   task automatic t_count();
      load(16'h0000);
      wr(CTL, 8'h03);
      frame(1'b0, 6);
      wr(CTL, 8'h00);
      rd16();
      check(cnt, 16'h0002);
      wr(CTL, 8'h0A);
      idle(20);
      wr(CTL, 8'h0B);
      frame(1'b1, 6);
      frame(1'b0, 6);
      wr(CTL, 8'h03);
      frame(1'b1, 6);
      wr(CTL, 8'h00);
      rd16();
      check(cnt, 16'h0004);
   endtask
   task automatic t_sleep();
      load(16'h0000);
      sleep_mode <= 1'b1;
      wr(CTL, 8'h03);
      frame(1'b0, 6);
      wr(CTL, 8'h00);
      rd16();
      check(cnt, 16'h0000);
      load(16'hFFFF);
      wr(counter_pkg::OFF_ENABLE, 8'h01);
      wr(CTL, 8'h07);
      frame(1'b0, 4);
      check(wake_request, 1'b1);
      wr(CTL, 8'h00);
      rd16();
      check(cnt, 16'h0000);
      sleep_mode <= 1'b0;
      wr(counter_pkg::OFF_FLAG, 8'h00);
      idle(1);
   endtask
   // reset with run bit clear: control clears, count bytes keep their value
   task automatic t_reset();
      load(16'h5A3C);
      wr(CTL, 8'h3A);
      idle(1);
      rst_n <= 1'b0;
      idle(2);
      rst_n <= 1'b1;
      idle(1);
      rd(CTL);
      check(got, 8'h00);
      rd16();
      check(cnt, 16'h5A3C);
   endtask
   // ==========================================
   // verdict, clock, sequence and watchdog
   task automatic summarize();
      $display("checks %0d, mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   initial begin
      rst_n = 1'b0;
      address = 8'h00;
      write_data = 8'h00;
      write_strobe = 1'b0;
      read_strobe = 1'b0;
      sleep_mode = 1'b0;
      special_event = 1'b0;
      src_enable = 1'b0;
      src_use_osc = 1'b0;
      err_total = 0;
      num_checks = 0;
      // count bytes have no reset; load them under reset so they are known
      repeat (2) @(posedge clock);
      load(16'hA5C3);
      @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      t_regs();
      $display("register test done");
      t_prescale();
      $display("prescale test done");
      t_wrap();
      $display("wrap test done");
      t_special();
      $display("special event test done");
      t_count();
      $display("counter mode test done");
      t_sleep();
      $display("sleep test done");
      t_reset();
      $display("reset test done");
      summarize();
   end
   // whole run is well under 2000 cycles
   initial begin
      repeat (20000) @(posedge clock);
      err_total++;
      summarize();
   end
endmodule
`default_nettype wire
